//--- rtl/fci_irq_ctrl.sv
`timescale 1ns/10ps
`include "fci_map.svh"
module fci_irq_ctrl (
  input wire logic clk_i,   // Card clock
  input wire logic rst_n_i, // Synchronous reset, active low
  fci_irq_if.ctrl  bus      // Lines, mask, clear and result
);

  fci_pkg::fci_line_t prev_reg;
  fci_pkg::fci_line_t pending_reg;
  fci_pkg::fci_line_t pending_next;
  fci_pkg::fci_line_t hit;
  fci_pkg::fci_line_t active;
  fci_pkg::fci_line_t rise;
  fci_pkg::fci_line_t fall;
  logic [2:0]         vec;

  assign rise = bus.level & ~prev_reg;
  assign fall = ~bus.level & prev_reg;

  // Four responses per line
  always_comb
  begin
    hit = '0;
    for (int i = 0; i < 8; i++)
    begin
      case (bus.mode[2*i +: 2])
        `FCI_MODE_LEVEL: hit[i] = bus.level[i];
        `FCI_MODE_RISE:  hit[i] = rise[i];
        `FCI_MODE_FALL:  hit[i] = fall[i];
        default:         hit[i] = rise[i] | fall[i];
      endcase
    end
  end

  // A new event beats a clear in the same cycle
  assign pending_next = (pending_reg & ~bus.clear) | hit;
  assign active       = pending_reg & bus.enable;

  // Lowest line number wins
  always_comb
  begin
    vec = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (active[i])
      begin
        vec = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prev_reg    <= '0;
      pending_reg <= '0;
    end
    else
    begin
      prev_reg    <= bus.level;
      pending_reg <= pending_next;
    end
  end

  assign bus.pending = pending_reg;
  assign bus.irq     = |active;
  assign bus.vector  = vec;

endmodule : fci_irq_ctrl

//--- rtl/fci_irq_if.sv
`timescale 1ns/10ps
interface fci_irq_if;
  fci_pkg::fci_line_t  level;
  fci_pkg::fci_line_t  enable;
  fci_pkg::fci_line_t  clear;
  fci_pkg::fci_modes_t mode;
  fci_pkg::fci_line_t  pending;
  logic                irq;
  logic [2:0]          vector;

  modport ctrl (
    input  level,
    input  enable,
    input  clear,
    input  mode,
    output pending,
    output irq,
    output vector
  );

  modport host (
    output level,
    output enable,
    output clear,
    output mode,
    input  pending,
    input  irq,
    input  vector
  );
endinterface : fci_irq_if

//--- rtl/fci_map.svh
// What this block does
// - Fourteen prioritised maskable request lines, each but init with four selectable responses.
// - Lines 0-6: transfer done, service, L1 error, L2 error, init, L1 busy, L2 busy.
// - Lines 7-13: L1/L2 decision, L1/L2 accept, L2 reject, FIFO overflow, FIFO empty.
// - Init request fires only on the init signal's rising edge.
// - Decode FIFO ctrl +0, control +0x200, sequencer +0x400, card ID +0x600.
// - Decode first interrupt controller +0x800, second +0xA00.
// - Decode error record controller +0xC00; +0xE00 is spare.
// - Timekeeping memory 56K from +0x1000; dual-port memory 64K from +0x10000.
// - Host reads card identifier and serial number taken from switches.
// - Red indicators follow the first and second level error inputs.
// - Both red indicators flash together on internal failure.
// - Green indicators: bus access, sequencer timing source, computer access mode.
// - Front-panel push button resets the whole module except the button's own filter.
`ifndef FCI_MAP_SVH
`define FCI_MAP_SVH

`define FCI_AW 17
`define FCI_DP_BIT 16
`define FCI_CTRL_ADDR 17'h00200
`define FCI_MODE_LO_ADDR 17'h00204
`define FCI_MODE_HI_ADDR 17'h00208
`define FCI_INPUT_ADDR 17'h0020c
`define FCI_ID_ADDR 17'h00600
`define FCI_SERIAL_ADDR 17'h00604
`define FCI_IC1_BASE 17'h00800
`define FCI_IC2_BASE 17'h00a00
`define FCI_IC_STATUS 17'h00000
`define FCI_IC_ENABLE 17'h00004
`define FCI_IC_CLEAR 17'h00008
`define FCI_IC_VECTOR 17'h0000c

`define FCI_CTRL_CAM 0
`define FCI_CTRL_SEQ 1
`define FCI_CTRL_FAIL 2

`define FCI_MODE_LEVEL 2'h0
`define FCI_MODE_RISE 2'h1
`define FCI_MODE_FALL 2'h2
`define FCI_MODE_BOTH 2'h3
`define FCI_INIT_LINE 4

`define FCI_CLK_NS 100
`define FCI_NS_PER_MS 1000000
`define FCI_NS_PER_US 1000
`define FCI_BLINK_MS 250
`define FCI_ACCESS_US 100

`endif

//--- rtl/fci_pkg.sv
package fci_pkg;

  typedef logic [7:0]  fci_line_t;
  typedef logic [15:0] fci_modes_t;
  typedef logic [15:0] fci_half_t;

  typedef enum logic [3:0] {
    FCI_SEG_FIFO,
    FCI_SEG_CSR,
    FCI_SEG_SEQ,
    FCI_SEG_ID,
    FCI_SEG_IC1,
    FCI_SEG_IC2,
    FCI_SEG_ERR,
    FCI_SEG_SPARE,
    FCI_SEG_TIME,
    FCI_SEG_DPM
  } fci_seg_t;

endpackage : fci_pkg

//--- rtl/fci_top.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "fci_map.svh"
module fci_top #(
  parameter int unsigned BLINK_CYCLES =
    (`FCI_BLINK_MS * `FCI_NS_PER_MS) / `FCI_CLK_NS
) (
  input  wire logic        clk_i,                        // Card clock, 10 MHz
  input  wire logic        rst_n_i,                      // Synchronous reset
  input  wire logic        reset_button_n_i,             // Front-panel button
  input  wire logic [16:0] addr_i,                       // Card-relative address
  input  wire logic [31:0] wdata_i,                      // Write data
  input  wire logic        wr_i,                         // Write strobe
  input  wire logic        rd_i,                         // Read strobe
  output logic      [31:0] rdata_o,                      // Read data
  output logic      [9:0]  seg_sel_o,                    // Segment strobes
  input  wire logic        dma_done_i,                   // Transfer complete
  input  wire logic        service_request_i,            // Service request
  input  wire logic        first_level_error_i,          // L1 error
  input  wire logic        second_level_error_i,         // L2 error
  input  wire logic        init_i,                       // Init signal
  input  wire logic        first_level_busy_i,           // L1 busy
  input  wire logic        second_level_busy_i,          // L2 busy
  input  wire logic        first_level_decision_i,       // L1 decision
  input  wire logic        second_level_decision_i,      // L2 decision
  input  wire logic        first_level_accept_i,         // L1 accept
  input  wire logic        second_level_accept_i,        // L2 accept
  input  wire logic        second_level_reject_i,        // L2 reject
  input  wire logic        fifo_overflow_i,              // FIFO overflow
  input  wire logic        fifo_empty_flag_i,            // FIFO empty
  input  wire logic [15:0] card_identifier_i,            // ID switches
  input  wire logic [15:0] serial_number_i,              // Serial switches
  output logic             irq_o,                        // Interrupt, level
  output logic      [3:0]  irq_vector_o,                 // Winning line
  output logic             first_error_indicator_o,      // Red LED 1
  output logic             second_error_indicator_o,     // Red LED 2
  output logic             vme_access_indicator_o,       // Green LED, access
  output logic             sequencer_source_indicator_o, // Green LED, sequencer
  output logic             computer_access_mode_o,       // Green LED, mode
  output logic             card_reset_n_o                // Module reset
);

  localparam int unsigned ACCESS_CYCLES =
    (`FCI_ACCESS_US * `FCI_NS_PER_US) / `FCI_CLK_NS;

  // Pin synchronisers
  logic [13:0] src_raw;
  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;
  logic [13:0] sync3_reg;
  logic [13:0] filt_reg;
  logic [13:0] filt_next;

  logic        btn1_reg;
  logic        btn2_reg;
  logic        btn3_reg;
  logic        btn_reg;
  logic        btn_next;
  logic        mod_rst_n;

  // Registers
  logic [2:0]          ctrl_reg;
  fci_pkg::fci_half_t  mode_lo_reg;
  fci_pkg::fci_half_t  mode_hi_reg;
  fci_pkg::fci_line_t  en1_reg;
  fci_pkg::fci_line_t  en2_reg;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic [3:0]          vector_reg;
  logic [3:0]          vector_next;

  // Indicator timing
  logic [21:0] blink_cnt_reg;
  logic [21:0] blink_cnt_next;
  logic        blink_reg;
  logic        blink_wrap;
  logic [9:0]  acc_cnt_reg;
  logic [9:0]  acc_cnt_next;
  logic        access;

  // Decode
  logic [2:0]  seg_idx;
  logic        in_low;
  logic        in_time;
  logic        in_dpm;
  logic [9:0]  seg_hit;
  logic [16:0] ic_off;
  logic        hit_ctrl;
  logic        hit_mode_lo;
  logic        hit_mode_hi;
  logic        hit_input;
  logic        hit_id;
  logic        hit_serial;
  logic        hit_status;
  logic        hit_enable;
  logic        hit_clear;
  logic        hit_vector;
  logic        wr_ic1;
  logic        wr_ic2;
  fci_pkg::fci_modes_t mode_lo_eff;

  fci_irq_if ic1 ();
  fci_irq_if ic2 ();

  assign src_raw = {fifo_empty_flag_i,
                    fifo_overflow_i,
                    second_level_reject_i,
                    second_level_accept_i,
                    first_level_accept_i,
                    second_level_decision_i,
                    first_level_decision_i,
                    second_level_busy_i,
                    first_level_busy_i,
                    init_i,
                    second_level_error_i,
                    first_level_error_i,
                    service_request_i,
                    dma_done_i};

  // A change counts once stages two and three agree
  assign filt_next = (sync2_reg & sync3_reg) |
                     (filt_reg & (sync2_reg ^ sync3_reg));
  assign btn_next  = (btn2_reg & btn3_reg) |
                     (btn_reg & (btn2_reg ^ btn3_reg));

  // Button pressed holds everything but its own filter in reset
  assign mod_rst_n = rst_n_i & ~btn_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      btn1_reg <= 1'b0;
      btn2_reg <= 1'b0;
      btn3_reg <= 1'b0;
      btn_reg  <= 1'b0;
    end
    else
    begin
      btn1_reg <= ~reset_button_n_i;
      btn2_reg <= btn1_reg;
      btn3_reg <= btn2_reg;
      btn_reg  <= btn_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!mod_rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg  <= '0;
    end
    else
    begin
      sync1_reg <= src_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  // Address decode
  assign seg_idx = addr_i[11:9];
  assign in_dpm  = addr_i[`FCI_DP_BIT];
  assign in_low  = ~in_dpm & (addr_i[15:12] == 4'h0);
  assign in_time = ~in_dpm & (addr_i[15:12] != 4'h0) &
                   (addr_i[15:12] != 4'hf);

  always_comb
  begin
    seg_hit = '0;
    if (in_low)
    begin
      seg_hit[seg_idx] = 1'b1;
    end
    seg_hit[fci_pkg::FCI_SEG_TIME] = in_time;
    seg_hit[fci_pkg::FCI_SEG_DPM]  = in_dpm;
  end

  assign access    = rd_i | wr_i;
  assign seg_sel_o = seg_hit & {10{access}};

  assign ic_off = seg_hit[fci_pkg::FCI_SEG_IC1] ?
                  addr_i - `FCI_IC1_BASE : addr_i - `FCI_IC2_BASE;

  assign hit_ctrl    = addr_i == `FCI_CTRL_ADDR;
  assign hit_mode_lo = addr_i == `FCI_MODE_LO_ADDR;
  assign hit_mode_hi = addr_i == `FCI_MODE_HI_ADDR;
  assign hit_input   = addr_i == `FCI_INPUT_ADDR;
  assign hit_id      = addr_i == `FCI_ID_ADDR;
  assign hit_serial  = addr_i == `FCI_SERIAL_ADDR;
  assign hit_status  = ic_off == `FCI_IC_STATUS;
  assign hit_enable  = ic_off == `FCI_IC_ENABLE;
  assign hit_clear   = ic_off == `FCI_IC_CLEAR;
  assign hit_vector  = ic_off == `FCI_IC_VECTOR;
  assign wr_ic1      = wr_i & seg_hit[fci_pkg::FCI_SEG_IC1];
  assign wr_ic2      = wr_i & seg_hit[fci_pkg::FCI_SEG_IC2];

  // Init line always answers the rising edge only
  always_comb
  begin
    mode_lo_eff = mode_lo_reg;
    mode_lo_eff[2*`FCI_INIT_LINE +: 2] = `FCI_MODE_RISE;
  end

  assign ic1.level  = filt_reg[7:0];
  assign ic1.enable = en1_reg;
  assign ic1.clear  = wdata_i[7:0] & {8{wr_ic1 & hit_clear}};
  assign ic1.mode   = mode_lo_eff;
  assign ic2.level  = {2'h0, filt_reg[13:8]};
  assign ic2.enable = en2_reg;
  assign ic2.clear  = wdata_i[7:0] & {8{wr_ic2 & hit_clear}};
  assign ic2.mode   = mode_hi_reg;

  fci_irq_ctrl u_ic1 (
    .clk_i   (clk_i),
    .rst_n_i (mod_rst_n),
    .bus     (ic1.ctrl)
  );

  fci_irq_ctrl u_ic2 (
    .clk_i   (clk_i),
    .rst_n_i (mod_rst_n),
    .bus     (ic2.ctrl)
  );

  // First controller outranks the second
  assign vector_next = ic1.irq ? {1'b0, ic1.vector} :
                       {1'b1, ic2.vector};

  // Read mux, data valid only in the cycle after the strobe
  always_comb
  begin
    rdata_next = '0;
    if (rd_i)
    begin
      if (hit_ctrl)
      begin
        rdata_next[2:0] = ctrl_reg;
      end
      else if (hit_mode_lo)
      begin
        rdata_next[15:0] = mode_lo_eff;
      end
      else if (hit_mode_hi)
      begin
        rdata_next[15:0] = mode_hi_reg;
      end
      else if (hit_input)
      begin
        rdata_next[13:0] = filt_reg;
      end
      else if (hit_id)
      begin
        rdata_next[15:0] = card_identifier_i;
      end
      else if (hit_serial)
      begin
        rdata_next[15:0] = serial_number_i;
      end
      else if (seg_hit[fci_pkg::FCI_SEG_IC1] & hit_status)
      begin
        rdata_next[7:0] = ic1.pending;
      end
      else if (seg_hit[fci_pkg::FCI_SEG_IC1] & hit_enable)
      begin
        rdata_next[7:0] = en1_reg;
      end
      else if (seg_hit[fci_pkg::FCI_SEG_IC1] & hit_vector)
      begin
        rdata_next[3:0] = {ic1.irq, ic1.vector};
      end
      else if (seg_hit[fci_pkg::FCI_SEG_IC2] & hit_status)
      begin
        rdata_next[7:0] = ic2.pending;
      end
      else if (seg_hit[fci_pkg::FCI_SEG_IC2] & hit_enable)
      begin
        rdata_next[7:0] = en2_reg;
      end
      else if (seg_hit[fci_pkg::FCI_SEG_IC2] & hit_vector)
      begin
        rdata_next[3:0] = {ic2.irq, ic2.vector};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!mod_rst_n)
    begin
      ctrl_reg    <= '0;
      mode_lo_reg <= '0;
      mode_hi_reg <= '0;
      en1_reg     <= '0;
      en2_reg     <= '0;
    end
    else if (wr_i)
    begin
      if (hit_ctrl)
      begin
        ctrl_reg <= wdata_i[2:0];
      end
      if (hit_mode_lo)
      begin
        mode_lo_reg <= wdata_i[15:0];
      end
      if (hit_mode_hi)
      begin
        mode_hi_reg <= wdata_i[15:0];
      end
      if (wr_ic1 & hit_enable)
      begin
        en1_reg <= wdata_i[7:0];
      end
      if (wr_ic2 & hit_enable)
      begin
        en2_reg <= wdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!mod_rst_n)
    begin
      rdata_reg  <= '0;
      vector_reg <= '0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      vector_reg <= vector_next;
    end
  end

  // Blink timebase and access stretch
  assign blink_wrap     = blink_cnt_reg == 22'(BLINK_CYCLES - 1);
  assign blink_cnt_next = blink_wrap ? 22'h0 : blink_cnt_reg + 22'h1;
  assign acc_cnt_next   = access ? 10'(ACCESS_CYCLES) :
                          (acc_cnt_reg != 10'h0) ? acc_cnt_reg - 10'h1 :
                          10'h0;

  always_ff @(posedge clk_i)
  begin
    if (!mod_rst_n)
    begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
      acc_cnt_reg   <= '0;
    end
    else
    begin
      blink_cnt_reg <= blink_cnt_next;
      blink_reg     <= blink_reg ^ blink_wrap;
      acc_cnt_reg   <= acc_cnt_next;
    end
  end

  // Failure flashes both red lights in step
  always_ff @(posedge clk_i)
  begin
    if (!mod_rst_n)
    begin
      first_error_indicator_o      <= 1'b0;
      second_error_indicator_o     <= 1'b0;
      vme_access_indicator_o       <= 1'b0;
      sequencer_source_indicator_o <= 1'b0;
      computer_access_mode_o       <= 1'b0;
    end
    else if (ctrl_reg[`FCI_CTRL_FAIL])
    begin
      first_error_indicator_o      <= blink_reg;
      second_error_indicator_o     <= blink_reg;
      vme_access_indicator_o       <= acc_cnt_reg != 10'h0;
      sequencer_source_indicator_o <= ctrl_reg[`FCI_CTRL_SEQ];
      computer_access_mode_o       <= ctrl_reg[`FCI_CTRL_CAM];
    end
    else
    begin
      first_error_indicator_o      <= filt_reg[2];
      second_error_indicator_o     <= filt_reg[3];
      vme_access_indicator_o       <= acc_cnt_reg != 10'h0;
      sequencer_source_indicator_o <= ctrl_reg[`FCI_CTRL_SEQ];
      computer_access_mode_o       <= ctrl_reg[`FCI_CTRL_CAM];
    end
  end

  assign rdata_o        = rdata_reg;
  assign irq_vector_o   = vector_reg;
  assign irq_o          = ic1.irq | ic2.irq;
  assign card_reset_n_o = mod_rst_n;

endmodule : fci_top

//--- verif/fci_src_model.sv
`timescale 1ns/10ps
module fci_src_model (
  input  wire logic        clk_i, // Card clock
  input  wire logic [13:0] req_i, // Wanted source levels
  output logic      [13:0] pin_o  // Source pins, line n on bit n
);
  // Sources change just after the edge, like the backplane drivers
  initial pin_o = 14'h0000;
  always @(posedge clk_i) pin_o <= req_i;
endmodule : fci_src_model

//--- verif/fci_top_properties.sv
`timescale 1ns/10ps
module fci_top_properties (
  input wire logic        clk_i,             // Card clock
  input wire logic        rst_n_i,           // Synchronous reset
  input wire logic        reset_button_n_i,  // Front-panel button
  input wire logic [16:0] addr_i,            // Card-relative address
  input wire logic        wr_i,              // Write strobe
  input wire logic        rd_i,              // Read strobe
  input wire logic [31:0] rdata_o,           // Read data
  input wire logic [9:0]  seg_sel_o,         // Segment strobes
  input wire logic [15:0] card_identifier_i, // ID switches
  input wire logic [15:0] serial_number_i,   // Serial switches
  input wire logic        irq_o,             // Interrupt
  input wire logic [3:0]  irq_vector_o,      // Winning line
  input wire logic        card_reset_n_o     // Module reset
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  wire logic acc;
  assign acc = rd_i || wr_i;

  a_seg_low : assert property (
    acc && addr_i < 17'h01000 |-> seg_sel_o == 10'(10'h001 << addr_i[11:9]))
    else $error("segment strobe wrong below 0x1000");
  a_seg_time : assert property (
    acc && addr_i inside {[17'h01000:17'h0efff]} |-> seg_sel_o == 10'h100)
    else $error("timekeeping segment not selected");
  a_seg_dpm : assert property (
    acc && addr_i[16] |-> seg_sel_o == 10'h200)
    else $error("dual-port segment not selected");
  a_seg_idle : assert property (
    !acc |-> seg_sel_o == 10'h000)
    else $error("segment strobe without access");
  a_unmapped_zero : assert property (
    rd_i && addr_i inside {[17'h0f000:17'h0ffff]} |=> rdata_o == 32'h0)
    else $error("unmapped read returned data");
  a_rdata_idle : assert property (
    !rd_i |=> rdata_o == 32'h0)
    else $error("read data outside answer cycle");
  a_id_read : assert property (
    rd_i && addr_i == 17'h00600 |=> rdata_o == {16'h0000, $past(card_identifier_i)})
    else $error("card identifier read wrong");
  a_serial_read : assert property (
    rd_i && addr_i == 17'h00604 |=> rdata_o == {16'h0000, $past(serial_number_i)})
    else $error("serial number read wrong");
  a_vector_range : assert property (
    irq_o && $past(irq_o) |-> irq_vector_o <= 4'hd)
    else $error("vector names an unused line");
  a_button_reset : assert property (
    !reset_button_n_i [*8] |-> !card_reset_n_o)
    else $error("button press did not reset module");
  a_reset_holds : assert property (
    disable iff (1'b0) !rst_n_i |-> !card_reset_n_o)
    else $error("module reset released during reset");
endmodule : fci_top_properties

bind fci_top fci_top_properties u_props (
  .clk_i, .rst_n_i, .reset_button_n_i, .addr_i, .wr_i, .rd_i, .rdata_o, .seg_sel_o,
  .card_identifier_i, .serial_number_i, .irq_o, .irq_vector_o, .card_reset_n_o
);

//--- verif/tb.sv
`timescale 1ns/10ps
`include "fci_map.svh"
module tb;
  localparam logic [16:0] IC1 = `FCI_IC1_BASE;
  localparam logic [16:0] IC2 = `FCI_IC2_BASE;
  localparam logic [16:0] EN  = `FCI_IC_ENABLE;
  localparam logic [16:0] CL  = `FCI_IC_CLEAR;
  localparam logic [16:0] VC  = `FCI_IC_VECTOR;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        btn_n   = 1'b1;
  logic [16:0] addr    = 17'h0;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [13:0] req     = 14'h0;
  logic [15:0] id_sw   = 16'h0;
  logic [15:0] sn_sw   = 16'h0;
  logic [31:0] rnd     = 32'h90beb32d;
  logic [13:0] src;
  logic [31:0] rdata_o;
  logic [9:0]  seg_sel_o;
  logic        irq_o;
  logic [3:0]  irq_vector_o;
  logic        fe, se, va, sq, computer_access_mode, crst, p;
  logic [31:0] d;
  logic [9:0]  s;
  logic [16:0] ad;
  logic [16:0] amap [13] = '{17'h00000, 17'h00200, 17'h00400, 17'h00600, 17'h00800, 17'h00a00,
                             17'h00c00, 17'h00e00, 17'h01000, 17'h0effc, 17'h0f000, 17'h10000, 17'h1fffc};
  int          fail_count = 0;
  int          num_checks = 0;
  int          a, b, c, tog;

  always #50 clk_i = ~clk_i;

  fci_src_model i_src (.clk_i(clk_i), .req_i(req), .pin_o(src));

  fci_top #(.BLINK_CYCLES(4)) i_dut (
    .clk_i, .rst_n_i, .reset_button_n_i(btn_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o, .seg_sel_o, .dma_done_i(src[0]), .service_request_i(src[1]), .first_level_error_i(src[2]),
    .second_level_error_i(src[3]), .init_i(src[4]), .first_level_busy_i(src[5]),
    .second_level_busy_i(src[6]), .first_level_decision_i(src[7]), .second_level_decision_i(src[8]),
    .first_level_accept_i(src[9]), .second_level_accept_i(src[10]), .second_level_reject_i(src[11]),
    .fifo_overflow_i(src[12]), .fifo_empty_flag_i(src[13]), .card_identifier_i(id_sw),
    .serial_number_i(sn_sw), .irq_o, .irq_vector_o, .first_error_indicator_o(fe),
    .second_error_indicator_o(se), .vme_access_indicator_o(va), .sequencer_source_indicator_o(sq),
    .computer_access_mode_o(computer_access_mode), .card_reset_n_o(crst)
  );

  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function logic [9:0] exp_seg(input logic [16:0] x);
    if (x[16]) return 10'h200;
    if (x >= 17'h0f000) return 10'h000;
    if (x >= 17'h01000) return 10'h100;
    return 10'(10'h001 << x[11:9]);
  endfunction : exp_seg

  // Register contents straight after reset; init line mode always reads back rising
  function logic [31:0] exp_rd(input logic [16:0] x);
    if (x == `FCI_ID_ADDR) return {16'h0, id_sw};
    if (x == `FCI_SERIAL_ADDR) return {16'h0, sn_sw};
    if (x == `FCI_MODE_LO_ADDR) return 32'h100;
    return 32'h0;
  endfunction : exp_rd

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task bus_wr(input logic [16:0] x, input logic [31:0] v);
    @(posedge clk_i);
    addr <= x; wdata <= v; wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : bus_wr

  task rd_chk(input logic [16:0] x, input logic [31:0] exp);
    @(posedge clk_i);
    addr <= x; rd <= 1'b1;
    @(negedge clk_i);
    s = seg_sel_o;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
    chk(d, exp);
  endtask : rd_chk

  task drive(input logic [13:0] v);
    @(posedge clk_i);
    req <= v;
  endtask : drive

  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  task clr_all;
    bus_wr(IC1 + CL, 32'hff);
    bus_wr(IC2 + CL, 32'hff);
  endtask : clr_all

  task wait_irq;
    for (int i = 0; i < 30; i++)
    begin
      @(negedge clk_i);
      if (irq_o === 1'b1) return;
    end
    fail_count++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, irq_o, 1'b1);
    end_sim;
  endtask : wait_irq

  initial
  begin
    idle(1);
    id_sw <= rnd[15:0];
    sn_sw <= rnd[31:16];
    idle(7);
    rst_n_i <= 1'b1;
    rd_chk(IC1, 32'h0);
    rd_chk(IC2 + EN, 32'h0);
    rd_chk(`FCI_ID_ADDR, {16'h0, id_sw});
    rd_chk(`FCI_SERIAL_ADDR, {16'h0, sn_sw});
    $display("test reset_and_id done");
    bus_wr(17'h00400, rnd);
    for (int i = 0; i < 21; i++)
    begin
      rnd = lfsr(rnd);
      ad = (i < 13) ? amap[i] : {rnd[16:2], 2'b00};
      rd_chk(ad, exp_rd(ad));
      chk(s, exp_seg(ad));
    end
    $display("test decode done");
    bus_wr(IC1 + EN, 32'hff);
    bus_wr(IC2 + EN, 32'h3f);
    rd_chk(IC2 + EN, 32'h3f);
    for (int n = 0; n < 14; n++)
    begin
      drive(14'(1) << n);
      wait_irq;
      idle(2);
      @(negedge clk_i);
      chk(irq_vector_o, n);
      rd_chk(n < 8 ? IC1 : IC2, 32'(1) << (n % 8));
      drive(14'h0);
      idle(8);
      clr_all;
      @(negedge clk_i);
      chk(irq_o, 0);
    end
    for (int k = 0; k < 6; k++)
    begin
      rnd = lfsr(rnd);
      a = (k == 0) ? 3 : (k == 1) ? 8 : rnd[3:0] % 14;
      b = (k == 0) ? 9 : (k == 1) ? 13 : rnd[7:4] % 14;
      drive((14'(1) << a) | (14'(1) << b));
      wait_irq;
      idle(3);
      @(negedge clk_i);
      c = (a < b) ? a : b;
      chk(irq_vector_o, c);
      rd_chk((c < 8 ? IC1 : IC2) + VC, 32'h8 | (c % 8));
      drive(14'h0);
      idle(8);
      clr_all;
    end
    $display("test priority done");
    bus_wr(IC1 + EN, 32'h0);
    drive(14'h0004);
    idle(8);
    rd_chk(IC1, 32'h4);
    chk(irq_o, 0);
    bus_wr(IC1 + EN, 32'hff);
    @(negedge clk_i);
    chk(irq_o, 1);
    drive(14'h0010);
    idle(8);
    clr_all;
    idle(8);
    rd_chk(IC1, 32'h0);
    drive(14'h0);
    idle(8);
    clr_all;
    $display("test mask_and_init done");
    for (int m = 0; m < 4; m++)
    begin
      bus_wr(`FCI_MODE_LO_ADDR, m);
      rd_chk(`FCI_MODE_LO_ADDR, 32'h100 | m);
      drive(14'h0001);
      idle(8);
      rd_chk(IC1, 32'(m != 2));
      clr_all;
      rd_chk(IC1, 32'(m == 0));
      drive(14'h0);
      idle(8);
      rd_chk(IC1, 32'(m != 1));
      clr_all;
    end
    bus_wr(`FCI_MODE_LO_ADDR, 32'hffff);
    rd_chk(`FCI_MODE_LO_ADDR, 32'hfdff);
    bus_wr(`FCI_MODE_LO_ADDR, 32'h0);
    bus_wr(`FCI_MODE_HI_ADDR, 32'h1);
    rd_chk(`FCI_MODE_HI_ADDR, 32'h1);
    drive(14'h0100);
    idle(8);
    clr_all;
    rd_chk(IC2, 32'h0);
    drive(14'h0);
    idle(8);
    bus_wr(`FCI_MODE_HI_ADDR, 32'h0);
    $display("test modes done");
    drive(14'h0004);
    idle(8);
    @(negedge clk_i);
    chk({fe, se}, 2'b10);
    rd_chk(`FCI_INPUT_ADDR, 32'h4);
    drive(14'h0008);
    idle(8);
    @(negedge clk_i);
    chk({fe, se}, 2'b01);
    drive(14'h0);
    idle(8);
    clr_all;
    bus_wr(`FCI_CTRL_ADDR, 32'h3);
    idle(2);
    @(negedge clk_i);
    chk({computer_access_mode, sq, va}, 3'b111);
    bus_wr(`FCI_CTRL_ADDR, 32'h4);
    tog = 0;
    p = fe;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk_i);
      chk(fe, se);
      tog += (fe !== p);
      p = fe;
    end
    chk(tog > 2, 1);
    bus_wr(`FCI_CTRL_ADDR, 32'h0);
    idle(1100);
    @(negedge clk_i);
    chk({computer_access_mode, sq, va}, 3'b000);
    $display("test indicators done");
    @(posedge clk_i);
    btn_n <= 1'b0;
    idle(10);
    @(negedge clk_i);
    chk(crst, 0);
    @(posedge clk_i);
    btn_n <= 1'b1;
    idle(10);
    @(negedge clk_i);
    chk(crst, 1);
    rd_chk(IC1 + EN, 32'h0);
    $display("test button done");
    end_sim;
  end
endmodule : tb
